/* pkg/lsd_pkg.sv */
// constants, register map and carrier types for the segment lcd control block
package lsd_pkg;

   // register word indices; the byte address is four times the index
   localparam logic [9:0] LSD_IDX_CTRL_A = 10'h00E4;
   localparam logic [9:0] LSD_IDX_CTRL_B = 10'h00E5;
   localparam logic [9:0] LSD_IDX_CONTRAST = 10'h00E7;
   localparam logic [9:0] LSD_IDX_ROW0 = 10'h00EC;
   localparam int LSD_ROWS = 4;
   localparam int LSD_SEGS = 25;
   localparam int LSD_COMS = 4;

   // reset values
   localparam logic [7:0] LSD_RST_CTRL_A = 8'h00;
   localparam logic [7:0] LSD_RST_CTRL_B = 8'h00;
   localparam logic [7:0] LSD_RST_CONTRAST = 8'h00;

   // control register a bit positions
   localparam int LSD_A_ENABLE = 7;
   localparam int LSD_A_LOWPOWER = 6;
   localparam int LSD_A_FLAG = 4;
   localparam int LSD_A_IRQEN = 3;
   localparam int LSD_A_BUFDIS = 2;
   localparam int LSD_A_SUPPLYDIS = 1;
   localparam int LSD_A_BLANK = 0;

   // control register b bit positions
   localparam int LSD_B_CLKSEL = 7;
   localparam int LSD_B_HALFBIAS = 6;
   localparam int LSD_B_DUTY_LSB = 4;
   localparam int LSD_B_MASK_LSB = 0;

   // software settings of register a, flag held apart
   typedef struct packed {
      logic driverEnable;
      logic lowPowerWaveformSelect;
      logic frameStartIrqEnable;
      logic levelBufferDisable;
      logic internalSupplyDisable;
      logic displayBlanking;
   } lsd_ctrl_a_t;

   // software settings of register b
   typedef struct packed {
      logic panelClockSelect;
      logic halfBiasSelect;
      logic [1:0] dutySelect;
      logic [2:0] segmentPinMask;
   } lsd_ctrl_b_t;

   // settings taken over at a frame boundary
   typedef struct packed {
      logic displayBlanking;
      logic lowPowerWaveformSelect;
      logic [7:0] contrastSettings;
   } lsd_latch_t;

endpackage

/* src/lsd_control.sv */
// control, frame sequencing and register slave of the segment lcd driver
//
// How it works
// - capture memory, blanking, waveform, contrast at frame
// - register writes accepted any time, may tear
// - disabled controller releases all lcd pins
// - enable starts; clearing enable stops immediately
// - waveform select takes effect next frame
// - reserved bits read zero, not writable
// - frame flag set with each capture
// - interrupt when flag, enable, global enable
// - flag clears on vector or write one
// - low power waveform captures every second frame
// - buffer disable bypasses level buffers
// - supply disable turns internal generator off
// - blanking grounds all pins after frame
// - clock select: system or asynchronous source
// - bias select: third or half bias, ignored at duty 0
// - duty field selects used commons
// - pin mask selects used segment pins
`timescale 1ns/1ps
module lsd_control
   import lsd_pkg::*;
#(
   parameter int PHASE_TICKS = 16
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic globalInterruptEnable,
   input wire logic irqVectorTaken,
   input wire logic timerOscillatorPin,
   input wire logic externalClockPin,
   input wire logic externalClockInputSelect,
   output logic frameIrq,
   output logic [LSD_SEGS-1:0] segmentOutputs,
   output logic [LSD_COMS-1:0] commonOutputs,
   output logic [LSD_SEGS-1:0] segmentPinOwned,
   output logic [LSD_COMS-1:0] commonPinOwned,
   output logic driveGround,
   output logic lowPowerActive,
   output logic halfBiasActive,
   output logic levelBufferBypass,
   output logic internalSupplyOff,
   output logic [7:0] contrastActive,
   output logic asyncClockActive
);

   localparam int TW = $clog2(PHASE_TICKS + 1);

   lsd_ctrl_a_t ctrlA;
   lsd_ctrl_b_t ctrlB;
   lsd_latch_t latched;
   logic frameStartFlag;
   logic [7:0] contrastSettings;
   logic [LSD_SEGS-1:0] displayMemory [LSD_ROWS];
   logic [LSD_SEGS-1:0] activeMemory [LSD_ROWS];
   logic asyncSync1;
   logic asyncSync2;
   logic asyncSync3;
   logic lcdTick;
   logic [TW-1:0] tickCount;
   logic [1:0] commonIndex;
   logic startPending;
   logic frameParity;
   logic frameEnd;
   logic frameBoundary;
   logic capture;
   logic apbAccess;
   logic apbWrite;
   logic [9:0] wordIndex;
   logic writeA;
   logic [31:0] readValue;
   logic mapped;

   // segment pins in use for a pin mask code
   function automatic logic [LSD_SEGS-1:0] segMask(input logic [2:0] code);
      logic [4:0] used;
      used = 5'd0;
      case (code)
         3'd0: used = 5'd13;
         3'd1: used = 5'd15;
         3'd2: used = 5'd17;
         3'd3: used = 5'd19;
         3'd4: used = 5'd21;
         3'd5: used = 5'd23;
         3'd6: used = 5'd24;
         default: used = 5'd25;
      endcase
      return LSD_SEGS'((32'h0000_0001 << used) - 32'h0000_0001);
   endfunction

   // common pins in use for a duty code
   function automatic logic [LSD_COMS-1:0] comMask(input logic [1:0] duty);
      return LSD_COMS'((5'h02 << duty) - 5'h01);
   endfunction

   // bus decode; a request completes on the edge where pready is high
   assign apbAccess = psel && penable && pready;
   assign apbWrite = apbAccess && pwrite;
   assign wordIndex = paddr[11:2];
   assign writeA = apbWrite && (wordIndex == LSD_IDX_CTRL_A);

   // read multiplexer; reserved bits come back as zero
   always_comb
   begin
      readValue = 32'h0000_0000;
      mapped = 1'b1;
      if (wordIndex == LSD_IDX_CTRL_A)
         readValue[7:0] = {ctrlA.driverEnable, ctrlA.lowPowerWaveformSelect, 1'b0, frameStartFlag,
                           ctrlA.frameStartIrqEnable, ctrlA.levelBufferDisable,
                           ctrlA.internalSupplyDisable, ctrlA.displayBlanking};
      else if (wordIndex == LSD_IDX_CTRL_B)
         readValue[7:0] = {ctrlB.panelClockSelect, ctrlB.halfBiasSelect, ctrlB.dutySelect, 1'b0,
                           ctrlB.segmentPinMask};
      else if (wordIndex == LSD_IDX_CONTRAST)
         readValue[7:0] = contrastSettings;
      else if (wordIndex >= LSD_IDX_ROW0 && wordIndex < LSD_IDX_ROW0 + 10'(LSD_ROWS))
         readValue[LSD_SEGS-1:0] = displayMemory[2'(wordIndex - LSD_IDX_ROW0)];
      else
         mapped = 1'b0;
   end

   // one wait state: pready, read data and error rise together
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (psel && penable && !pready)
            prdata <= pwrite ? 32'h0000_0000 : readValue;
      end
   end

   // control register a settings, writable at any time
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ctrlA <= lsd_ctrl_a_t'(6'h00);
         startPending <= 1'b0;
      end
      else
      begin
         if (writeA)
         begin
            ctrlA.driverEnable <= pwdata[LSD_A_ENABLE];
            ctrlA.lowPowerWaveformSelect <= pwdata[LSD_A_LOWPOWER];
            ctrlA.frameStartIrqEnable <= pwdata[LSD_A_IRQEN];
            ctrlA.levelBufferDisable <= pwdata[LSD_A_BUFDIS];
            ctrlA.internalSupplyDisable <= pwdata[LSD_A_SUPPLYDIS];
            ctrlA.displayBlanking <= pwdata[LSD_A_BLANK];
         end
         // a fresh enable opens the first frame at once
         if (writeA && pwdata[LSD_A_ENABLE] && !ctrlA.driverEnable)
            startPending <= 1'b1;
         else if (frameBoundary || !ctrlA.driverEnable)
            startPending <= 1'b0;
      end
   end

   // control register b and contrast settings
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ctrlB <= lsd_ctrl_b_t'(7'h00);
         contrastSettings <= LSD_RST_CONTRAST;
      end
      else if (apbWrite)
      begin
         if (wordIndex == LSD_IDX_CTRL_B)
            ctrlB <= {pwdata[LSD_B_CLKSEL], pwdata[LSD_B_HALFBIAS], pwdata[LSD_B_DUTY_LSB +: 2],
                      pwdata[LSD_B_MASK_LSB +: 3]};
         if (wordIndex == LSD_IDX_CONTRAST)
            contrastSettings <= pwdata[7:0];
      end
   end

   // display memory written by software, one row per common
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         for (int r = 0; r < LSD_ROWS; r++)
            displayMemory[r] <= '0;
      end
      else if (apbWrite && wordIndex >= LSD_IDX_ROW0 && wordIndex < LSD_IDX_ROW0 + 10'(LSD_ROWS))
         displayMemory[2'(wordIndex - LSD_IDX_ROW0)] <= pwdata[LSD_SEGS-1:0];
   end

   // asynchronous lcd clock source brought in through a synchroniser
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         asyncSync1 <= 1'b0;
         asyncSync2 <= 1'b0;
         asyncSync3 <= 1'b0;
      end
      else
      begin
         asyncSync1 <= externalClockInputSelect ? externalClockPin : timerOscillatorPin;
         asyncSync2 <= asyncSync1;
         asyncSync3 <= asyncSync2;
      end
   end

   // lcd tick: every system clock, or each synchronised source rise
   assign lcdTick = ctrlB.panelClockSelect ? (asyncSync2 && !asyncSync3) : 1'b1;

   // frame ends after the last used common phase
   assign frameEnd = lcdTick && (tickCount == TW'(PHASE_TICKS - 1)) && (commonIndex >= ctrlB.dutySelect);
   assign frameBoundary = ctrlA.driverEnable && (startPending || frameEnd);
   // low power waveform only captures on even frames
   assign capture = frameBoundary && (!latched.lowPowerWaveformSelect || !frameParity);

   // phase and common sequencing, stopped and cleared when disabled
   always_ff @(posedge sys_clk)
   begin
      if (reset || !ctrlA.driverEnable)
      begin
         tickCount <= '0;
         commonIndex <= 2'd0;
         frameParity <= 1'b0;
      end
      else if (startPending)
      begin
         tickCount <= '0;
         commonIndex <= 2'd0;
         frameParity <= 1'b1;
      end
      else if (lcdTick)
      begin
         if (tickCount == TW'(PHASE_TICKS - 1))
         begin
            tickCount <= '0;
            commonIndex <= frameEnd ? 2'd0 : commonIndex + 2'd1;
            if (frameEnd)
               frameParity <= !frameParity;
         end
         else
            tickCount <= tickCount + TW'(1);
      end
   end

   // frame boundary capture of memory and latched settings
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         latched <= lsd_latch_t'(10'h000);
         for (int r = 0; r < LSD_ROWS; r++)
            activeMemory[r] <= '0;
      end
      else if (capture)
      begin
         latched.displayBlanking <= ctrlA.displayBlanking;
         latched.lowPowerWaveformSelect <= ctrlA.lowPowerWaveformSelect;
         latched.contrastSettings <= contrastSettings;
         for (int r = 0; r < LSD_ROWS; r++)
            activeMemory[r] <= displayMemory[r];
      end
   end

   // start of frame flag; a capture wins over a clear in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         frameStartFlag <= 1'b0;
      else if (capture)
         frameStartFlag <= 1'b1;
      else if (irqVectorTaken || (writeA && pwdata[LSD_A_FLAG]))
         frameStartFlag <= 1'b0;
   end

   // interrupt request
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         frameIrq <= 1'b0;
      else
         frameIrq <= frameStartFlag && ctrlA.frameStartIrqEnable && globalInterruptEnable;
   end

   // pin ownership; everything returns to port use when disabled
   always_ff @(posedge sys_clk)
   begin
      if (reset || !ctrlA.driverEnable)
      begin
         segmentPinOwned <= '0;
         commonPinOwned <= '0;
      end
      else
      begin
         segmentPinOwned <= segMask(ctrlB.segmentPinMask);
         commonPinOwned <= comMask(ctrlB.dutySelect);
      end
   end

   // segment and common drive; blanking grounds every pin
   always_ff @(posedge sys_clk)
   begin
      if (reset || !ctrlA.driverEnable || latched.displayBlanking)
      begin
         segmentOutputs <= '0;
         commonOutputs <= '0;
      end
      else
      begin
         segmentOutputs <= activeMemory[commonIndex] & segMask(ctrlB.segmentPinMask);
         commonOutputs <= LSD_COMS'(4'h1 << commonIndex) & comMask(ctrlB.dutySelect);
      end
   end

   // analog control levels
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         driveGround <= 1'b0;
         lowPowerActive <= 1'b0;
         halfBiasActive <= 1'b0;
         levelBufferBypass <= 1'b0;
         internalSupplyOff <= 1'b0;
         contrastActive <= LSD_RST_CONTRAST;
         asyncClockActive <= 1'b0;
      end
      else
      begin
         driveGround <= ctrlA.driverEnable && latched.displayBlanking;
         lowPowerActive <= latched.lowPowerWaveformSelect;
         halfBiasActive <= ctrlB.halfBiasSelect && (ctrlB.dutySelect != 2'd0);
         levelBufferBypass <= ctrlA.levelBufferDisable;
         internalSupplyOff <= ctrlA.internalSupplyDisable;
         contrastActive <= latched.contrastSettings;
         asyncClockActive <= ctrlB.panelClockSelect;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence sWriteA;
      writeA;
   endsequence

   sequence sDisableWrite;
      writeA && !pwdata[LSD_A_ENABLE];
   endsequence

   a_reserved_read_zero: assert property (pready && !pwrite && $past(psel && penable && wordIndex == LSD_IDX_CTRL_A)
      |-> prdata[5] == 1'b0) else $error("reserved bit of register a read as one");

   a_flag_on_capture: assert property (capture |=> frameStartFlag)
      else $error("flag not set by frame capture");

   a_flag_write_clear: assert property (sWriteA ##0 pwdata[LSD_A_FLAG] && !capture |=> !frameStartFlag)
      else $error("writing one did not clear the flag");

   a_flag_write_keep: assert property (sWriteA ##0 !pwdata[LSD_A_FLAG] && frameStartFlag && !irqVectorTaken
      |=> frameStartFlag) else $error("writing zero cleared the flag");

   a_irq_request: assert property (frameIrq == $past(frameStartFlag && ctrlA.frameStartIrqEnable
      && globalInterruptEnable)) else $error("interrupt request wrong");

   a_disable_release: assert property (sDisableWrite |=> ##1 (segmentPinOwned == '0 && commonPinOwned == '0
      && segmentOutputs == '0)) else $error("pins not released after disable");

   a_lowpower_skip: assert property (frameBoundary && latched.lowPowerWaveformSelect && frameParity
      |-> !capture ##1 !frameStartFlag || $past(frameStartFlag)) else $error("low power captured odd frame");

   a_blank_ground: assert property (latched.displayBlanking |=> segmentOutputs == '0 && commonOutputs == '0)
      else $error("blanked display still driven");

   a_capture_data: assert property (capture |=> activeMemory[0] == $past(displayMemory[0])
      && latched.contrastSettings == $past(contrastSettings)) else $error("frame capture lost data");

endmodule

/* tb/lsd_glass.sv */
// passive segment glass model that remembers the pattern seen on each common
`timescale 1ns/1ps
module lsd_glass
#(
   parameter int SEGS = 25
)
(
   input wire logic sys_clk,
   input wire logic [SEGS-1:0] segmentOutputs,
   input wire logic [3:0] commonOutputs,
   output logic [3:0][SEGS-1:0] rowSeen
);
   // the glass only darkens segments under the one common being driven
   always_ff @(posedge sys_clk)
   begin
      for (int c = 0; c < 4; c++)
      begin
         if (commonOutputs == 4'(1 << c))
         begin
            rowSeen[c] <= segmentOutputs;
         end
      end
   end
endmodule

/* tb/tb.sv */
// self-checking bench for the segment lcd control block
`timescale 1ns/1ps
module tb;
   import lsd_pkg::*;
   typedef struct packed {logic rd; logic err; logic [31:0] data;} lsd_note_t;
   logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic globalInterruptEnable = 1'b0, irqVectorTaken = 1'b0, timerOscillatorPin = 1'b0;
   logic externalClockPin = 1'b0, externalClockInputSelect = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, frameIrq, driveGround, lowPowerActive, halfBiasActive;
   logic levelBufferBypass, internalSupplyOff, asyncClockActive;
   logic [24:0] segmentOutputs, segmentPinOwned;
   logic [3:0] commonOutputs, commonPinOwned;
   logic [7:0] contrastActive, contrast;
   logic [3:0][24:0] rowSeen, rows;
   logic [31:0] seed = 32'h6543_6358;
   int error_cnt = 0, num_checks = 0, n, ph = 0;
   lsd_note_t notes[$];
   lsd_note_t note;

   lsd_control #(.PHASE_TICKS(16)) dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .globalInterruptEnable(globalInterruptEnable), .irqVectorTaken(irqVectorTaken),
      .timerOscillatorPin(timerOscillatorPin), .externalClockPin(externalClockPin),
      .externalClockInputSelect(externalClockInputSelect), .frameIrq(frameIrq),
      .segmentOutputs(segmentOutputs), .commonOutputs(commonOutputs), .segmentPinOwned(segmentPinOwned),
      .commonPinOwned(commonPinOwned), .driveGround(driveGround), .lowPowerActive(lowPowerActive),
      .halfBiasActive(halfBiasActive), .levelBufferBypass(levelBufferBypass),
      .internalSupplyOff(internalSupplyOff), .contrastActive(contrastActive),
      .asyncClockActive(asyncClockActive));

   lsd_glass glass (.sys_clk(sys_clk), .segmentOutputs(segmentOutputs), .commonOutputs(commonOutputs),
      .rowSeen(rowSeen));

   // free running system clock
   always #5 sys_clk = ~sys_clk;

   // slow asynchronous source and a noisy alternative source
   always @(posedge sys_clk)
   begin
      ph <= (ph == 6) ? 0 : ph + 1;
      if (ph == 6)
         timerOscillatorPin <= ~timerOscillatorPin;
      externalClockPin <= seed[7];
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer; the note holds what the monitor must see
   task apb(input logic wr, input logic [9:0] idx, input logic [31:0] d, input logic err);
      int k;
      k = 0;
      notes.push_back({~wr, err, d});
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1 && k < 20)
      begin
         @(posedge sys_clk);
         k++;
      end
      if (k >= 20)
         chk("pready wait", 32'h0, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // wait for a rising edge of the frame interrupt, counting clock cycles
   task wrise(input int lim, output int cnt);
      logic old;
      cnt = 0;
      old = 1'b1;
      while ((old !== 1'b0 || frameIrq !== 1'b1) && cnt < lim)
      begin
         old = frameIrq;
         @(posedge sys_clk);
         cnt++;
      end
      if (cnt >= lim)
         chk("frame start seen", 32'h0, 32'h1);
   endtask

   // distance between two frame interrupts; the vector clears a standing flag first
   task gap(output int cnt);
      irqVectorTaken <= 1'b1;
      @(posedge sys_clk);
      irqVectorTaken <= 1'b0;
      wrise(400, cnt);
      irqVectorTaken <= 1'b1;
      @(posedge sys_clk);
      irqVectorTaken <= 1'b0;
      wrise(400, cnt);
      cnt = cnt + 1;
   endtask

   // compare each completed transfer with the oldest note
   always @(posedge sys_clk)
   begin
      if (psel && penable && pready === 1'b1)
      begin
         chk("note queue", 32'(notes.size() != 0), 32'h1);
         note = notes.pop_front();
         chk("pslverr", pslverr, note.err);
         if (note.rd)
            chk("prdata", prdata, note.data);
      end
   end

   task end_of_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog against a hung handshake or a frame that never starts
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      end_of_test();
   end

   // main sequence
   initial
   begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      apb(1'b0, LSD_IDX_CTRL_A, 32'h0000_0000, 1'b0);
      apb(1'b0, LSD_IDX_CTRL_B, 32'h0000_0000, 1'b0);
      apb(1'b1, LSD_IDX_CTRL_A, 32'h0000_0020, 1'b0);
      apb(1'b0, LSD_IDX_CTRL_A, 32'h0000_0000, 1'b0);
      apb(1'b1, LSD_IDX_CTRL_B, 32'h0000_00FF, 1'b0);
      apb(1'b0, LSD_IDX_CTRL_B, 32'h0000_00F7, 1'b0);
      apb(1'b0, 10'h0E6, 32'h0000_0000, 1'b1);
      apb(1'b1, 10'h0E6, rnd(), 1'b1);
      // configuration before enabling: contrast, display rows, duty and mask
      contrast = rnd() & 32'h0000_00FF;
      apb(1'b1, LSD_IDX_CONTRAST, {24'h0, contrast}, 1'b0);
      apb(1'b0, LSD_IDX_CONTRAST, {24'h0, contrast}, 1'b0);
      for (int c = 0; c < 4; c++)
      begin
         rows[c] = rnd() & 32'h01FF_FFFF;
         apb(1'b1, LSD_IDX_ROW0 + 10'(c), {7'h0, rows[c]}, 1'b0);
      end
      apb(1'b1, LSD_IDX_CTRL_B, 32'h0000_003F, 1'b0);
      globalInterruptEnable <= 1'b1;
      apb(1'b1, LSD_IDX_CTRL_A, 32'h0000_008E, 1'b0);
      wrise(400, n);
      chk("buffer bypass", levelBufferBypass, 32'h1);
      chk("supply off", internalSupplyOff, 32'h1);
      chk("contrast latched", contrastActive, contrast);
      apb(1'b0, LSD_IDX_CTRL_A, 32'h0000_009E, 1'b0);
      repeat (70) @(posedge sys_clk);
      for (int c = 0; c < 4; c++)
         chk("glass row", rowSeen[c], rows[c]);
      // every duty and pin mask code with half bias requested
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, LSD_IDX_CTRL_B, {24'h0, 2'b01, 2'(i), 1'b0, 3'(i)}, 1'b0);
         repeat (3) @(posedge sys_clk);
         chk("segment pins", segmentPinOwned, (32'h1 << ((i < 5) ? 13 + 2 * i : 18 + i)) - 1);
         chk("common pins", commonPinOwned, (32'h1 << (i % 4 + 1)) - 1);
         chk("half bias", halfBiasActive, 32'((i % 4) != 0));
      end
      apb(1'b1, LSD_IDX_CTRL_B, 32'h0000_003F, 1'b0);
      gap(n);
      chk("frame period", n, 64);
      apb(1'b1, LSD_IDX_CTRL_A, 32'h0000_009E, 1'b0);
      apb(1'b0, LSD_IDX_CTRL_A, 32'h0000_008E, 1'b0);
      apb(1'b1, LSD_IDX_CTRL_A, 32'h0000_00CE, 1'b0);
      chk("waveform before frame", lowPowerActive, 32'h0);
      gap(n);
      gap(n);
      chk("low power period", n, 128);
      chk("waveform after frame", lowPowerActive, 32'h1);
      // shutdown: blank and clear flag, wait for a frame, then disable
      apb(1'b1, LSD_IDX_CTRL_A, 32'h0000_009F, 1'b0);
      chk("ground before frame", driveGround, 32'h0);
      wrise(400, n);
      repeat (3) @(posedge sys_clk);
      chk("ground after frame", driveGround, 32'h1);
      chk("commons blanked", commonOutputs, 32'h0);
      chk("segments blanked", segmentOutputs, 32'h0);
      globalInterruptEnable <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("irq masked", frameIrq, 32'h0);
      apb(1'b1, LSD_IDX_CTRL_A, 32'h0000_008F, 1'b0);
      apb(1'b0, LSD_IDX_CTRL_A, 32'h0000_009F, 1'b0);
      globalInterruptEnable <= 1'b1;
      apb(1'b1, LSD_IDX_CTRL_A, 32'h0000_0010, 1'b0);
      repeat (3) @(posedge sys_clk);
      chk("segment pins off", segmentPinOwned, 32'h0);
      chk("common pins off", commonPinOwned, 32'h0);
      chk("ground released", driveGround, 32'h0);
      apb(1'b0, LSD_IDX_CTRL_A, 32'h0000_0000, 1'b0);
      // asynchronous panel clock
      apb(1'b1, LSD_IDX_CTRL_B, 32'h0000_00BF, 1'b0);
      repeat (3) @(posedge sys_clk);
      chk("async clock", asyncClockActive, 32'h1);
      apb(1'b1, LSD_IDX_CTRL_A, 32'h0000_0088, 1'b0);
      wrise(3000, n);
      end_of_test();
   end
endmodule
